// *** rtl/hirq_map.svh ***
`ifndef HIRQ_MAP_SVH
`define HIRQ_MAP_SVH

// ****************************************
// timing
// ****************************************
`define HIRQ_CLK_PERIOD_PS 4000
`define HIRQ_INIT_NS       100

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define HIRQ_OFS_CTRL   5'h00
`define HIRQ_OFS_STAT   5'h04
`define HIRQ_OFS_MASK   5'h08
`define HIRQ_OFS_STRAP  5'h0C
`define HIRQ_OFS_BASE_A 5'h10
`define HIRQ_OFS_BASE_B 5'h14

// ****************************************
// field positions
// ****************************************
`define HIRQ_CTRL_MODE  0
`define HIRQ_CTRL_CFG   1
`define HIRQ_CTRL_SUSP  2
`define HIRQ_CTRL_PIN   3
`define HIRQ_STRAP_ASEL 0
`define HIRQ_STRAP_CSEL 2
`define HIRQ_STRAP_ADDR 8
`define HIRQ_STRAP_FREQ 16

// ****************************************
// clock select codes, frequency in 100 kHz units
// ****************************************
`define HIRQ_CSEL_38M4  2'h0
`define HIRQ_CSEL_26M0  2'h1
`define HIRQ_CSEL_19M2  2'h2
`define HIRQ_CSEL_12M0  2'h3
`define HIRQ_FREQ_38M4  9'h180
`define HIRQ_FREQ_26M0  9'h104
`define HIRQ_FREQ_19M2  9'h0C0
`define HIRQ_FREQ_12M0  9'h078

// ****************************************
// reset values
// ****************************************
`define HIRQ_BASE_A_RST 7'h08
`define HIRQ_BASE_B_RST 7'h28
`define HIRQ_RD_ZERO    32'h0000_0000

`endif

// *** rtl/hirq_pkg.sv ***
package hirq_pkg;
    typedef enum logic [1:0] {
        ST_STANDBY = 2'b00,
        ST_INIT    = 2'b01,
        ST_RUN     = 2'b10
    } hirq_state_e;
    typedef logic [6:0] hirq_addr_t;
    typedef logic [8:0] hirq_freq_t;
endpackage

// *** rtl/hirq_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module hirq_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // async levels in, synchronised out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// *** rtl/hirq_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hirq_map.svh"
// Function
// RL1: one mode bit chooses interrupt pin behaviour
// RL2: mode 0: enabled status update pulls pin low
// RL3: writing status register releases pin high
// RL4: mode 1: pin low unless configured and active
// RL5: system picks bus current from pin level
// RL6: two-bit address strap sampled once at init
// RL7: strap[1] picks base, strap[0] gives lsb
// RL8: clock-select strap latched during init
// RL9: reset pin low holds device in standby
// RL10: decode 00/01/10/11 to 38.4/26.0/19.2/12.0 MHz
// RL11: interrupt pin is open drain only
module hirq_top
    import hirq_pkg::*;
#(
    parameter int unsigned NEVT     = 8,
    parameter int unsigned INIT_CYC = (`HIRQ_INIT_NS * 1000 + `HIRQ_CLK_PERIOD_PS - 1) / `HIRQ_CLK_PERIOD_PS
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            reset,
    // avalon-mm slave
    input  wire logic [4:0]      avs_address,
    input  wire logic            avs_read,
    input  wire logic            avs_write,
    input  wire logic [31:0]     avs_writedata,
    input  wire logic [3:0]      avs_byteenable,
    output logic      [31:0]     avs_readdata,
    output logic                 avs_waitrequest,
    // device pins
    input  wire logic            reset_n_pin,
    input  wire logic [1:0]      slave_addr_strap,
    input  wire logic [1:0]      clk_sel_strap,
    output logic                 int_n_o,
    output logic                 int_n_oe,
    // hub core side
    input  wire logic [NEVT-1:0] evt_upd,
    input  wire logic            hub_configured,
    input  wire logic            hub_suspended,
    output logic      [6:0]      slave_addr,
    output logic      [1:0]      ref_sel,
    output logic      [8:0]      ref_freq,
    output logic                 standby,
    output logic                 irq
);
    localparam int CW = $clog2(INIT_CYC + 1);

    if (NEVT < 1 || NEVT > 8) begin : g_chk_nevt
        $error("NEVT must be 1..8");
    end
    if (INIT_CYC < 1 || INIT_CYC > 4096) begin : g_chk_init
        $error("INIT_CYC must be 1..4096");
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic hirq_addr_t pick_addr(input logic [1:0] s, input hirq_addr_t a, input hirq_addr_t b);
        pick_addr = {(s[1] ? b[6:1] : a[6:1]), s[0]};
    endfunction

    function automatic hirq_freq_t dec_freq(input logic [1:0] c);
        unique case (c)
            `HIRQ_CSEL_38M4: dec_freq = `HIRQ_FREQ_38M4;
            `HIRQ_CSEL_26M0: dec_freq = `HIRQ_FREQ_26M0;
            `HIRQ_CSEL_19M2: dec_freq = `HIRQ_FREQ_19M2;
            `HIRQ_CSEL_12M0: dec_freq = `HIRQ_FREQ_12M0;
        endcase
    endfunction

    // ****************************************
    // pin synchronisers and reset
    // ****************************************
    logic [4:0] pin_s;
    logic       rst_int;

    hirq_sync #(
        .W (5)
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({reset_n_pin, clk_sel_strap, slave_addr_strap}),
        .q     (pin_s)
    );

    assign rst_int = reset | ~pin_s[4]; // RL9

    // ****************************************
    // standby / init sequencer
    // ****************************************
    hirq_state_e     state_ff;
    hirq_state_e     nxt_state;
    logic [CW-1:0]   cnt_ff;
    logic [1:0]      asel_ff;
    logic [1:0]      csel_ff;
    logic            init_done;

    assign init_done = (state_ff == ST_INIT) && (cnt_ff == CW'(INIT_CYC - 1));

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_STANDBY: nxt_state = ST_INIT;
            ST_INIT:    nxt_state = init_done ? ST_RUN : ST_INIT;
            ST_RUN:     nxt_state = ST_RUN;
            default:    nxt_state = ST_STANDBY;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst_int) begin
            state_ff <= ST_STANDBY; // RL9
            cnt_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= (state_ff == ST_INIT) ? cnt_ff + 1'b1 : '0;
        end
    end

    // straps caught once, at the end of init
    always_ff @(posedge clk) begin
        if (rst_int) begin
            asel_ff <= '0;
            csel_ff <= '0;
        end else if (init_done) begin
            asel_ff <= pin_s[1:0]; // RL6
            csel_ff <= pin_s[3:2]; // RL8
        end
    end

    always_ff @(posedge clk) begin
        if (rst_int) begin
            standby <= 1'b1; // RL9
        end else begin
            standby <= (nxt_state == ST_STANDBY);
        end
    end

    // ****************************************
    // avalon-mm handshake, one wait state
    // ****************************************
    logic        acc;
    logic        wr_go;
    logic [31:0] nxt_rdata;
    logic        mode_ff;
    logic [NEVT-1:0] stat_ff;
    logic [NEVT-1:0] mask_ff;
    hirq_addr_t  base_a_ff;
    hirq_addr_t  base_b_ff;

    assign acc   = (avs_read | avs_write) & avs_waitrequest;
    assign wr_go = avs_write & ~avs_waitrequest & avs_byteenable[0] & ~rst_int;

    always_comb begin
        nxt_rdata = `HIRQ_RD_ZERO;
        unique case (avs_address)
            `HIRQ_OFS_CTRL: begin
                nxt_rdata[`HIRQ_CTRL_MODE] = mode_ff;
                nxt_rdata[`HIRQ_CTRL_CFG]  = hub_configured;
                nxt_rdata[`HIRQ_CTRL_SUSP] = hub_suspended;
                nxt_rdata[`HIRQ_CTRL_PIN]  = int_n_oe;
            end
            `HIRQ_OFS_STAT:   nxt_rdata = 32'(stat_ff);
            `HIRQ_OFS_MASK:   nxt_rdata = 32'(mask_ff);
            `HIRQ_OFS_STRAP: begin
                nxt_rdata[`HIRQ_STRAP_ASEL +: 2] = asel_ff;
                nxt_rdata[`HIRQ_STRAP_CSEL +: 2] = csel_ff;
                nxt_rdata[`HIRQ_STRAP_ADDR +: 7] = slave_addr;
                nxt_rdata[`HIRQ_STRAP_FREQ +: 9] = ref_freq;
            end
            `HIRQ_OFS_BASE_A: nxt_rdata = 32'(base_a_ff);
            `HIRQ_OFS_BASE_B: nxt_rdata = 32'(base_b_ff);
            default:          nxt_rdata = `HIRQ_RD_ZERO;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= `HIRQ_RD_ZERO;
        end else begin
            avs_waitrequest <= ~acc;
            if (acc && avs_read) begin
                avs_readdata <= nxt_rdata;
            end
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst_int) begin
            mode_ff   <= 1'b0;
            mask_ff   <= '0;
            base_a_ff <= `HIRQ_BASE_A_RST;
            base_b_ff <= `HIRQ_BASE_B_RST;
        end else if (wr_go) begin
            if (avs_address == `HIRQ_OFS_CTRL) begin
                mode_ff <= avs_writedata[`HIRQ_CTRL_MODE]; // RL1
            end
            if (avs_address == `HIRQ_OFS_MASK) begin
                mask_ff <= avs_writedata[NEVT-1:0];
            end
            if (avs_address == `HIRQ_OFS_BASE_A) begin
                base_a_ff <= avs_writedata[6:0];
            end
            if (avs_address == `HIRQ_OFS_BASE_B) begin
                base_b_ff <= avs_writedata[6:0];
            end
        end
    end

    // ****************************************
    // status, set wins over write-one-clear
    // ****************************************
    logic [NEVT-1:0] stat_clr;

    assign stat_clr = (wr_go && avs_address == `HIRQ_OFS_STAT) ? avs_writedata[NEVT-1:0] : '0;

    always_ff @(posedge clk) begin
        if (rst_int) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= (stat_ff & ~stat_clr) | evt_upd; // RL3
        end
    end

    // ****************************************
    // interrupt pin and outputs
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst_int) begin
            int_n_oe <= 1'b0;
            int_n_o  <= 1'b0;
            irq      <= 1'b0;
        end else begin
            int_n_o <= 1'b0; // RL11
            irq     <= |(stat_ff & mask_ff);
            if (mode_ff) begin
                int_n_oe <= ~(hub_configured & ~hub_suspended); // RL4
            end else begin
                int_n_oe <= |(stat_ff & mask_ff); // RL2
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst_int) begin
            slave_addr <= `HIRQ_BASE_A_RST;
            ref_sel    <= '0;
            ref_freq   <= `HIRQ_FREQ_38M4;
        end else begin
            slave_addr <= pick_addr(asel_ff, base_a_ff, base_b_ff); // RL7
            ref_sel    <= csel_ff;
            ref_freq   <= dec_freq(csel_ff); // RL10
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    property p_mode_sel;
        @(posedge clk) disable iff (reset)
        (!rst_int && mode_ff && hub_configured && !hub_suspended) |=> !int_n_oe;
    endproperty
    a_mode_sel: assert property (p_mode_sel) else $error("suspend mode ignored"); // RL1

    property p_gen_irq;
        @(posedge clk) disable iff (reset)
        (!rst_int && !mode_ff && |(stat_ff & mask_ff)) |=> int_n_oe;
    endproperty
    a_gen_irq: assert property (p_gen_irq) else $error("pin not pulled on status"); // RL2

    property p_release;
        @(posedge clk) disable iff (reset)
        (wr_go && avs_address == `HIRQ_OFS_STAT && !(|evt_upd) && !mode_ff
            && ((stat_ff & mask_ff & ~avs_writedata[NEVT-1:0]) == '0))
            |=> ((stat_ff & $past(avs_writedata[NEVT-1:0])) == '0) ##1 !int_n_oe;
    endproperty
    a_release: assert property (p_release) else $error("pin not released"); // RL3

    property p_susp;
        @(posedge clk) disable iff (reset)
        (!rst_int && mode_ff && !(hub_configured && !hub_suspended)) |=> int_n_oe;
    endproperty
    a_susp: assert property (p_susp) else $error("suspend level wrong"); // RL4

    property p_strap_once;
        @(posedge clk) disable iff (reset)
        (state_ff == ST_RUN) ##1 (state_ff == ST_RUN) |-> $stable(asel_ff) && $stable(csel_ff);
    endproperty
    a_strap_once: assert property (p_strap_once) else $error("strap relatched"); // RL6

    property p_addr;
        @(posedge clk) disable iff (reset)
        (!rst_int) ##1 (!rst_int) |-> slave_addr[0] == $past(asel_ff[0])
            && slave_addr[6:1] == ($past(asel_ff[1]) ? $past(base_b_ff[6:1]) : $past(base_a_ff[6:1]));
    endproperty
    a_addr: assert property (p_addr) else $error("slave address wrong"); // RL7

    property p_clk_latch;
        @(posedge clk) disable iff (rst_int)
        (state_ff == ST_INIT) ##1 (state_ff == ST_RUN) |-> csel_ff == $past(pin_s[3:2]);
    endproperty
    a_clk_latch: assert property (p_clk_latch) else $error("clock strap not latched"); // RL8

    property p_standby;
        @(posedge clk) disable iff (reset)
        !pin_s[4] |=> standby && state_ff == ST_STANDBY && !int_n_oe;
    endproperty
    a_standby: assert property (p_standby) else $error("standby not held"); // RL9

    property p_freq;
        @(posedge clk) disable iff (rst_int)
        (state_ff == ST_RUN) ##1 (state_ff == ST_RUN) |-> ref_freq ==
            ((ref_sel == `HIRQ_CSEL_38M4) ? `HIRQ_FREQ_38M4 : (ref_sel == `HIRQ_CSEL_26M0) ? `HIRQ_FREQ_26M0 :
             (ref_sel == `HIRQ_CSEL_19M2) ? `HIRQ_FREQ_19M2 : `HIRQ_FREQ_12M0);
    endproperty
    a_freq: assert property (p_freq) else $error("frequency decode wrong"); // RL10

    property p_open_drain;
        @(posedge clk) disable iff (reset)
        int_n_oe |-> !int_n_o;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high"); // RL11
endmodule
`default_nettype wire

// *** tb/hirq_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module hirq_pin_model (
    // pin from device
    input  wire logic int_n_o,
    input  wire logic int_n_oe,
    // system view
    output logic      int_n_line,
    output logic      full_current_ok
);
    // undriven pin floats to the pull-up level
    assign int_n_line      = int_n_oe ? int_n_o : 1'b1;
    // system draws full current only when pin is released
    assign full_current_ok = int_n_line;
endmodule
`default_nettype wire

// *** tb/hirq_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module hirq_top_tb;
    import hirq_pkg::*;
    logic        clk, reset, avs_read, avs_write, reset_n_pin, hub_configured, hub_suspended;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic        avs_waitrequest, int_n_o, int_n_oe, standby, irq, int_n_line, full_current_ok;
    logic [1:0]  slave_addr_strap, clk_sel_strap, ref_sel;
    logic [3:0]  avs_byteenable;
    logic [7:0]  evt_upd;
    logic [6:0]  slave_addr, base;
    logic [8:0]  ref_freq;
    logic [8:0]  freq_tab [4] = '{9'h180, 9'h104, 9'h0C0, 9'h078};
    int          err_total = 0;
    int          checks_done = 0;
    int          cyc = 0;

    hirq_top #(.NEVT(8), .INIT_CYC(2)) dut_u (
        .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .reset_n_pin(reset_n_pin),
        .slave_addr_strap(slave_addr_strap), .clk_sel_strap(clk_sel_strap), .int_n_o(int_n_o),
        .int_n_oe(int_n_oe), .evt_upd(evt_upd), .hub_configured(hub_configured),
        .hub_suspended(hub_suspended), .slave_addr(slave_addr), .ref_sel(ref_sel),
        .ref_freq(ref_freq), .standby(standby), .irq(irq)
    );
    hirq_pin_model pin_u (
        .int_n_o(int_n_o), .int_n_oe(int_n_oe), .int_n_line(int_n_line),
        .full_current_ok(full_current_ok)
    );

    // ****************************************
    // clock, reset, timeout
    // ****************************************
    initial clk = 1'b0;
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            finish_test();
        end
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h got %h", name, exp, got);
            err_total = err_total + 1;
        end
    endtask
    task automatic wait_answer();
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
    endtask
    task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        wait_answer();
        avs_write     <= 1'b0;
    endtask
    task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        wait_answer();
        d = avs_readdata;
        avs_read    <= 1'b0;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse_evt(input logic [7:0] e);
        @(posedge clk);
        evt_upd <= e;
        @(posedge clk);
        evt_upd <= 8'h00;
        cycles(3);
    endtask
    task automatic reinit(input logic [1:0] asel, input logic [1:0] csel);
        int n;
        @(posedge clk);
        reset_n_pin      <= 1'b0;
        slave_addr_strap <= asel;
        clk_sel_strap    <= csel;
        cycles(5);
        chk("standby in pin reset", 32'h1, {31'h0, standby});
        @(posedge clk);
        reset_n_pin <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n = n + 1;
        end while (standby !== 1'b0 && n < 100);
        cycles(3);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        reset = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 5'h00;
        avs_writedata = 32'h0; reset_n_pin = 1'b1; slave_addr_strap = 2'h0; clk_sel_strap = 2'h0;
        evt_upd = 8'h00; hub_configured = 1'b0; hub_suspended = 1'b0; avs_byteenable = 4'hF;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        bus_rd(5'h10, rd); chk("base_a reset", 32'h08, rd);
        bus_rd(5'h14, rd); chk("base_b reset", 32'h28, rd);
        bus_rd(5'h1C, rd); chk("unmapped read", 32'h0, rd);
        avs_byteenable <= 4'hE;
        bus_wr(5'h10, 32'h55);
        avs_byteenable <= 4'hF;
        bus_rd(5'h10, rd); chk("byte 0 disabled write", 32'h08, rd);
        $display("test bus done");

        for (int i = 0; i < 4; i++) begin
            reinit(i[1:0], i[1:0]);
            base = i[1] ? 7'h28 : 7'h08;
            chk("ref_sel", {30'h0, i[1:0]}, {30'h0, ref_sel});
            chk("ref_freq", {23'h0, freq_tab[i]}, {23'h0, ref_freq});
            chk("slave_addr", {25'h0, base[6:1], i[0]}, {25'h0, slave_addr});
            @(posedge clk);
            slave_addr_strap <= ~i[1:0];
            clk_sel_strap    <= ~i[1:0];
            cycles(6);
            chk("ref_sel held", {30'h0, i[1:0]}, {30'h0, ref_sel});
            chk("addr held", {25'h0, base[6:1], i[0]}, {25'h0, slave_addr});
        end
        bus_wr(5'h14, 32'h30);
        cycles(3);
        chk("addr from base_b", 32'h31, {25'h0, slave_addr});
        bus_rd(5'h0C, rd); chk("strap reg", 32'h0078_310F, rd);
        $display("test straps done");

        bus_wr(5'h08, 32'h1);
        pulse_evt(8'h02);
        chk("masked event pin", 32'h1, {31'h0, int_n_line});
        pulse_evt(8'h01);
        chk("event pin low", 32'h0, {31'h0, int_n_line});
        chk("event irq", 32'h1, {31'h0, irq});
        bus_rd(5'h04, rd); chk("status", 32'h3, rd);
        bus_wr(5'h04, 32'h1);
        cycles(2);
        chk("pin released", 32'h1, {31'h0, int_n_line});
        chk("irq cleared", 32'h0, {31'h0, irq});
        bus_rd(5'h04, rd); chk("status after clear", 32'h2, rd);
        bus_wr(5'h04, 32'h2);
        $display("test general interrupt done");

        bus_wr(5'h00, 32'h1);
        cycles(2);
        chk("unconfigured pin", 32'h0, {31'h0, int_n_line});
        @(posedge clk);
        hub_configured <= 1'b1;
        cycles(3);
        chk("active pin", 32'h1, {31'h0, full_current_ok});
        pulse_evt(8'h01);
        chk("mode 1 ignores event", 32'h1, {31'h0, int_n_line});
        @(posedge clk);
        hub_suspended <= 1'b1;
        cycles(3);
        chk("suspended pin", 32'h0, {31'h0, int_n_line});
        bus_rd(5'h00, rd); chk("ctrl", 32'hF, rd);
        $display("test suspend indicator done");
        finish_test();
    end
endmodule
`default_nettype wire
